// File: rtl/scmi_pkg.sv
package scmi_pkg;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 16;
   localparam int COUNT_W = 6;

   // opcodes, most significant bit first on the wire
   localparam logic [7:0] OPCODE_READ = 8'h03;
   localparam logic [7:0] OPCODE_WRITE = 8'h02;

   // bit counter values seen at the rising edge that carries a given bit
   localparam logic [COUNT_W-1:0] OPCODE_LAST_BIT = 6'h07;
   localparam logic [COUNT_W-1:0] LOOKUP_BIT = 6'h0e;
   localparam logic [COUNT_W-1:0] ADDR_LAST_BIT = 6'h0f;
   localparam logic [COUNT_W-1:0] DATA_FIRST_BIT = 6'h10;
   localparam logic [COUNT_W-1:0] DATA_LAST_BIT = 6'h1f;
   localparam logic [COUNT_W-1:0] FRAME_BITS = 6'h20;

   // core clock timing
   localparam int CLK_PERIOD_NS = 40;
   localparam int READ_LOW_NS = 200;
   localparam int READ_LOW_CYCLES_INT = (READ_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [3:0] READ_LOW_CYCLES = 4'(READ_LOW_CYCLES_INT);

   // core clock multiplier codes
   localparam logic [3:0] MULT_1X = 4'h0;

   localparam int SYNC_W = 5;

   typedef struct packed {
      logic valid;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] data;
   } scmi_word_t;

   typedef enum logic [1:0] {
      FETCH_IDLE = 2'b00,
      FETCH_EVEN = 2'b01,
      FETCH_ODD = 2'b10,
      FETCH_DONE = 2'b11
   } scmi_fetch_t;
endpackage : scmi_pkg

// File: rtl/scmi_sync.sv
module scmi_sync
   import scmi_pkg::*;
#(
   parameter int WIDTH = 1
) (
   input wire logic clk,
   input wire logic resetn,
   input wire logic ce,
   input wire logic [WIDTH-1:0] async,
   output logic [WIDTH-1:0] synced
);
   logic [WIDTH-1:0] stage1;

   // first stage feeds only the second stage
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         stage1 <= '0;
         synced <= '0;
      end else if (ce) begin
         stage1 <= async;
         synced <= stage1;
      end
   end
endmodule : scmi_sync

// File: rtl/scmi_image_mem.sv
module scmi_image_mem
   import scmi_pkg::*;
#(
   parameter int AW = ADDR_W,
   parameter int DW = DATA_W
) (
   input wire logic clk,
   input wire logic ce,
   input wire logic writeEn,
   input wire logic [AW-1:0] writeAddr,
   input wire logic [DW-1:0] writeData,
   input wire logic [AW-1:0] readAddr,
   output logic [DW-1:0] readData
);
   logic [DW-1:0] store [0:(1<<AW)-1];

   // no reset on the array; registered read
   always_ff @(posedge clk) begin
      if (ce) begin
         if (writeEn) begin
            store[writeAddr] <= writeData;
         end
         readData <= store[readAddr];
      end
   end
endmodule : scmi_image_mem

// File: rtl/scmi_command_port.sv
// Function
// - a transaction is opcode byte, address byte, then one 16-bit word
// - each transaction touches one register only, never a burst
// - input sampled on rising serial clock; host changes it on falling edge
// - every byte and word travels most significant bit first
// - arbitrary pauses between serial clock pulses are tolerated
// - opcode 8'h03 reads, opcode 8'h02 writes
// - data request flag goes low after every command operation
// - during a read, input after the address byte is ignored
// - after the read address, the 16-bit register word shifts out
// - a read pulls the data request flag low only briefly
// - after a write, flag stays low while the register update executes
// - shared mode syncs data bytes on rising shared select edge
// - select edges resynchronise both the command and data ports
// - core clock multiplier comes out of reset at 1.0
// - select high idles the port, aborts, and tristates serial output
// - read data launched on falling edge; output undriven during writes
// - shared mode derives data-port select by inverting command select
// - flag high guarantees room for 32 data bytes or one command
module scmi_command_port
   import scmi_pkg::*;
(
   input wire logic clk,
   input wire logic resetn,
   input wire logic ce,
   input wire logic serialClock,
   input wire logic commandSelectN,
   input wire logic serialIn,
   output logic serialOut,
   output logic serialOutEn,
   input wire logic dataPortSelectN,
   input wire logic sharedSelectMode,
   input wire logic dataRoomOk,
   input wire logic execDone,
   input wire scmi_word_t regUpdate,
   output scmi_word_t regWrite,
   input wire logic multLoad,
   input wire logic [3:0] multValue,
   output logic [3:0] coreClockMult,
   output logic dataRequestFlag,
   output logic dataPortActive,
   output logic dataByteSync
);
   // ---------------- link domain (serial clock) ----------------
   logic linkResetN;
   logic [COUNT_W-1:0] bitCount;
   logic [DATA_W-1:0] shiftIn;
   logic isRead;
   logic isWrite;
   logic [ADDR_W-1:0] writeAddr;
   logic [DATA_W-1:0] writeData;
   logic writeToggle;
   logic [ADDR_W-2:0] lookupAddr;
   logic lookupToggle;
   logic [DATA_W-1:0] outWord;
   logic [2*DATA_W-1:0] readPair;
   logic [4:0] outIndex;

   // select high holds the link side in reset, apart from the captured words and toggles
   assign linkResetN = resetn & ~commandSelectN;

   // gated clock is fine: only edges advance the state
   always_ff @(posedge serialClock or negedge linkResetN) begin
      if (!linkResetN) begin
         bitCount <= '0;
         shiftIn <= '0;
         isRead <= 1'b0;
         isWrite <= 1'b0;
      end else begin
         if (bitCount != FRAME_BITS) begin
            bitCount <= bitCount + 6'h01;
         end
         if (!(isRead && bitCount > ADDR_LAST_BIT) && bitCount != FRAME_BITS) begin
            shiftIn <= {shiftIn[DATA_W-2:0], serialIn};
         end
         if (bitCount == OPCODE_LAST_BIT) begin
            isRead <= {shiftIn[6:0], serialIn} == OPCODE_READ;
            isWrite <= {shiftIn[6:0], serialIn} == OPCODE_WRITE;
         end
      end
   end

   // captured words survive the end of the frame for the core side
   always_ff @(posedge serialClock or negedge resetn) begin
      if (!resetn) begin
         writeAddr <= '0;
         writeData <= '0;
         writeToggle <= 1'b0;
         lookupAddr <= '0;
         lookupToggle <= 1'b0;
      end else if (!commandSelectN) begin
         if (isWrite && bitCount == ADDR_LAST_BIT) begin
            writeAddr <= {shiftIn[6:0], serialIn};
         end
         // only a full 32-bit frame commits a write
         if (isWrite && bitCount == DATA_LAST_BIT) begin
            writeData <= {shiftIn[DATA_W-2:0], serialIn};
            writeToggle <= ~writeToggle;
         end
         // start the lookup one bit early: both candidate words get fetched
         if (isRead && bitCount == LOOKUP_BIT) begin
            lookupAddr <= {shiftIn[5:0], serialIn};
            lookupToggle <= ~lookupToggle;
         end
      end
   end

   // last address bit picks the even or odd word of the fetched pair
   always_ff @(posedge serialClock or negedge linkResetN) begin
      if (!linkResetN) begin
         outWord <= '0;
      end else if (isRead && bitCount == ADDR_LAST_BIT) begin
         outWord <= serialIn ? readPair[2*DATA_W-1:DATA_W] : readPair[DATA_W-1:0];
      end
   end

   assign outIndex = 5'(DATA_LAST_BIT - bitCount);

   always_ff @(negedge serialClock or negedge linkResetN) begin
      if (!linkResetN) begin
         serialOut <= 1'b0;
         serialOutEn <= 1'b0;
      end else begin
         // writes and unknown opcodes never drive the output
         serialOutEn <= isRead && bitCount >= DATA_FIRST_BIT;
         if (isRead && bitCount >= DATA_FIRST_BIT && bitCount <= DATA_LAST_BIT) begin
            serialOut <= outWord[outIndex[3:0]];
         end
      end
   end

   // ---------------- core domain ----------------
   logic [SYNC_W-1:0] syncIn;
   logic [SYNC_W-1:0] syncOut;
   logic selSync;
   logic dcsSync;
   logic shareSync;
   logic writeSync;
   logic lookupSync;
   logic selPrev;
   logic dcsPrev;
   logic writePrev;
   logic lookupPrev;
   logic writeEvent;
   logic lookupEvent;
   logic execBusy;
   logic [3:0] readLowCount;
   scmi_fetch_t fetchState;
   scmi_fetch_t next_fetchState;
   logic [ADDR_W-1:0] memReadAddr;
   logic [DATA_W-1:0] memReadData;

   function automatic logic edgeOf(input logic now, input logic prev);
      edgeOf = now ^ prev;
   endfunction : edgeOf

   // selects cross inverted so the synchroniser's reset value equals their idle high level
   assign syncIn = {commandSelectN, dataPortSelectN, sharedSelectMode, writeToggle, lookupToggle}
      ^ 5'h18;

   scmi_sync #(
      .WIDTH(SYNC_W)
   ) u_sync (
      .clk(clk),
      .resetn(resetn),
      .ce(ce),
      .async(syncIn),
      .synced(syncOut)
   );

   assign {selSync, dcsSync, shareSync, writeSync, lookupSync} = syncOut ^ 5'h18;
   assign writeEvent = edgeOf(writeSync, writePrev);
   assign lookupEvent = edgeOf(lookupSync, lookupPrev);

   // selPrev resets high so the first release is not taken as an edge
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         selPrev <= 1'b1;
         dcsPrev <= 1'b1;
         writePrev <= 1'b0;
         lookupPrev <= 1'b0;
      end else if (ce) begin
         selPrev <= selSync;
         dcsPrev <= dcsSync;
         writePrev <= writeSync;
         lookupPrev <= lookupSync;
      end
   end

   // register image that read commands return; the handler keeps it current
   scmi_image_mem #(
      .AW(ADDR_W),
      .DW(DATA_W)
   ) u_image (
      .clk(clk),
      .ce(ce),
      .writeEn(regUpdate.valid),
      .writeAddr(regUpdate.addr),
      .writeData(regUpdate.data),
      .readAddr(memReadAddr),
      .readData(memReadData)
   );

   // pair fetch must finish within 1 serial clock; holds at <= 1/7 core rate
   always_comb begin
      next_fetchState = fetchState;
      memReadAddr = {lookupAddr, 1'b0};
      unique case (fetchState)
         FETCH_IDLE: begin
            if (lookupEvent) begin
               next_fetchState = FETCH_EVEN;
            end
         end
         FETCH_EVEN: begin
            memReadAddr = {lookupAddr, 1'b1};
            next_fetchState = FETCH_ODD;
         end
         FETCH_ODD: begin
            next_fetchState = FETCH_DONE;
         end
         FETCH_DONE: begin
            next_fetchState = FETCH_IDLE;
         end
      endcase
   end

   // lookupAddr is stable here: it changed before the toggle was seen
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         fetchState <= FETCH_IDLE;
         readPair <= '0;
      end else if (ce) begin
         fetchState <= next_fetchState;
         // registered read: the odd word shows in ODD, the even word in DONE
         if (fetchState == FETCH_ODD) begin
            readPair[2*DATA_W-1:DATA_W] <= memReadData;
         end
         if (fetchState == FETCH_DONE) begin
            readPair[DATA_W-1:0] <= memReadData;
         end
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         regWrite <= '0;
      end else if (ce) begin
         regWrite.valid <= writeEvent;
         if (writeEvent) begin
            regWrite.addr <= writeAddr;
            regWrite.data <= writeData;
         end
      end
   end

   // a new write in the same cycle as execDone keeps the port busy
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         execBusy <= 1'b0;
      end else if (ce) begin
         if (writeEvent) begin
            execBusy <= 1'b1;
         end else if (execDone) begin
            execBusy <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         readLowCount <= '0;
      end else if (ce) begin
         if (lookupEvent) begin
            // the flag already drops in the event cycle; the counter covers the rest
            readLowCount <= READ_LOW_CYCLES - 4'h1;
         end else if (readLowCount != 4'h0) begin
            readLowCount <= readLowCount - 4'h1;
         end
      end
   end

   // low after every operation; high only with room in the data path
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         dataRequestFlag <= 1'b0;
      end else if (ce) begin
         // released in the very cycle execDone arrives, so the host sees it one cycle later
         dataRequestFlag <= dataRoomOk && !(execBusy && !execDone) && !writeEvent
            && !lookupEvent && readLowCount == 4'h0;
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         dataPortActive <= 1'b0;
         dataByteSync <= 1'b0;
      end else if (ce) begin
         if (shareSync) begin
            dataPortActive <= selSync;
            dataByteSync <= selSync && !selPrev;
         end else begin
            dataPortActive <= !dcsSync;
            dataByteSync <= !dcsSync && dcsPrev;
         end
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         coreClockMult <= MULT_1X;
      end else if (ce && multLoad) begin
         coreClockMult <= multValue;
      end
   end
endmodule : scmi_command_port

// File: verification/scmi_command_port_assertions.sv
module scmi_command_port_assertions
   import scmi_pkg::*;
(
   input wire logic clk,
   input wire logic resetn,
   input wire logic ce,
   input wire logic commandSelectN,
   input wire logic serialOutEn,
   input wire logic execDone,
   input wire scmi_word_t regWrite,
   input wire logic multLoad,
   input wire logic [3:0] multValue,
   input wire logic [3:0] coreClockMult,
   input wire logic dataRequestFlag,
   input wire logic dataRoomOk,
   input wire logic dataByteSync
);
   logic pend;
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         pend <= 1'b0;
      end else if (regWrite.valid) begin
         pend <= 1'b1;
      end else if (execDone) begin
         pend <= 1'b0;
      end
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);
   a_mult_load: assert property (multLoad && ce |=> coreClockMult == $past(multValue))
      else $error("multiplier load mismatch");
   a_mult_hold: assert property (!multLoad |=> $stable(coreClockMult))
      else $error("multiplier changed without load");
   a_out_idle: assert property (commandSelectN |-> !serialOutEn)
      else $error("serial output driven while deselected");
   a_flag_exec: assert property (regWrite.valid |=> !dataRequestFlag)
      else $error("flag high after write");
   a_flag_hold: assert property (pend && !execDone |=> !dataRequestFlag)
      else $error("flag rose before update done");
   a_flag_rise: assert property (pend && execDone && ce |=> dataRequestFlag)
      else $error("flag not released after update");
   a_read_low: assert property ($fell(dataRequestFlag) && !pend && !regWrite.valid
      && $past(dataRoomOk) |-> !dataRequestFlag [*5])
      else $error("read low pulse too short");
   a_wr_pulse: assert property (regWrite.valid |=> !regWrite.valid)
      else $error("write strobe longer than one cycle");
   a_sync_pulse: assert property (dataByteSync |=> !dataByteSync)
      else $error("byte sync longer than one cycle");
endmodule : scmi_command_port_assertions

bind scmi_command_port scmi_command_port_assertions scmi_command_port_assertions_inst (
   .clk(clk), .resetn(resetn), .ce(ce), .commandSelectN(commandSelectN),
   .serialOutEn(serialOutEn), .execDone(execDone), .regWrite(regWrite),
   .multLoad(multLoad), .multValue(multValue), .coreClockMult(coreClockMult),
   .dataRequestFlag(dataRequestFlag), .dataRoomOk(dataRoomOk), .dataByteSync(dataByteSync)
);

// File: verification/scmi_host_model.sv
module scmi_host_model (
   input wire logic sclkBase,
   input wire logic serialOut,
   input wire logic serialOutEn,
   output logic serialClock,
   output logic commandSelectN,
   output logic serialIn
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      serialClock = 1'b0;
      commandSelectN = 1'b1;
      serialIn = 1'b0;
   end
   // 12 base ticks per half keeps the serial clock under a seventh of the core clock
   task automatic half(input int n);
      repeat (n) @(posedge sclkBase);
   endtask : half
   task automatic frame(input logic [31:0] word, input int nbits, input int slow,
                        output logic [15:0] rd);
      rd = 16'h0000;
      @(posedge sclkBase);
      commandSelectN <= 1'b0;
      for (int i = 0; i < nbits; i++) begin
         serialIn <= word[31-i];
         half(12 + slow * (i % 3));
         if (i >= 16) begin
            rd = {rd[14:0], serialOutEn ? serialOut : 1'bx};
         end
         serialClock <= 1'b1;
         half(12);
         serialClock <= 1'b0;
      end
      half(12);
      commandSelectN <= 1'b1;
      serialIn <= ~serialIn;
      half(24);
   endtask : frame
endmodule : scmi_host_model

// File: verification/scmi_command_port_test.sv
module scmi_command_port_test
   import scmi_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0, sclkBase = 1'b0, resetn = 1'b0, ce = 1'b1, dataRoomOk = 1'b1;
   logic serialClock, commandSelectN, serialIn, serialOut, serialOutEn;
   logic dataPortSelectN = 1'b1, sharedSelectMode = 1'b0, execDone = 1'b0, multLoad = 1'b0;
   logic [3:0] multValue = 4'h0;
   logic [3:0] coreClockMult;
   logic dataRequestFlag, dataPortActive, dataByteSync;
   scmi_word_t regUpdate = '0;
   scmi_word_t regWrite, lastWr;
   logic [15:0] rd;
   int err_count = 0, n_checks = 0, wrCount = 0, lowCount = 0, syncCount = 0;
   always #20 clk = ~clk;
   initial begin
      #3;
      forever #6 sclkBase = ~sclkBase;
   end
   scmi_command_port scmi_command_port_inst (.clk(clk), .resetn(resetn), .ce(ce),
      .serialClock(serialClock), .commandSelectN(commandSelectN), .serialIn(serialIn),
      .serialOut(serialOut), .serialOutEn(serialOutEn), .dataPortSelectN(dataPortSelectN),
      .sharedSelectMode(sharedSelectMode), .dataRoomOk(dataRoomOk), .execDone(execDone),
      .regUpdate(regUpdate), .regWrite(regWrite), .multLoad(multLoad), .multValue(multValue),
      .coreClockMult(coreClockMult), .dataRequestFlag(dataRequestFlag),
      .dataPortActive(dataPortActive), .dataByteSync(dataByteSync));
   scmi_host_model scmi_host_model_inst (.sclkBase(sclkBase), .serialOut(serialOut),
      .serialOutEn(serialOutEn), .serialClock(serialClock),
      .commandSelectN(commandSelectN), .serialIn(serialIn));
   always @(posedge clk) begin
      if (regWrite.valid === 1'b1) begin
         wrCount <= wrCount + 1;
         lastWr <= regWrite;
      end
      if (dataRequestFlag === 1'b0) lowCount <= lowCount + 1;
      if (dataByteSync === 1'b1) syncCount <= syncCount + 1;
   end
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_checks++;
      if (got !== exp) begin
         err_count++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask : check
   task automatic print_verdict();
      $display("checks %0d, mismatches %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : print_verdict
   task automatic wait_flag();
      for (int i = 0; i < 60 && dataRequestFlag !== 1'b1; i++) @(negedge clk);
      check("request flag", 1, dataRequestFlag);
   endtask : wait_flag
   task automatic t_read(input logic [7:0] a, input logic [15:0] d);
      int low0, wr0;
      low0 = lowCount;
      wr0 = wrCount;
      // trailing input bits are a changing pattern the device must ignore
      scmi_host_model_inst.frame({OPCODE_READ, a, 16'h5a5a}, 32, 1, rd);
      wait_flag();
      check("read data", d, rd);
      check("read low cycles", READ_LOW_CYCLES_INT, lowCount - low0);
      check("read writes", wr0, wrCount);
      $display("read test done");
   endtask : t_read
   task automatic t_write();
      scmi_host_model_inst.frame({OPCODE_WRITE, 8'h33, 16'hc3a5}, 32, 2, rd);
      repeat (8) @(negedge clk);
      check("write strobe count", 1, wrCount);
      check("write word", {7'h0, 1'b1, 8'h33, 16'hc3a5}, {7'h0, lastWr});
      check("write output idle", {16'h0, 16'hxxxx}, {16'h0, rd});
      check("flag during update", 0, dataRequestFlag);
      execDone <= 1'b1;
      @(negedge clk);
      execDone <= 1'b0;
      wait_flag();
      $display("write test done");
   endtask : t_write
   task automatic t_refuse();
      scmi_host_model_inst.frame({8'h01, 8'h33, 16'hffff}, 32, 0, rd);
      wait_flag();
      scmi_host_model_inst.frame({OPCODE_WRITE, 8'h34, 16'h1111}, 20, 0, rd);
      repeat (20) @(negedge clk);
      check("refused strobe count", 1, wrCount);
      $display("refuse test done");
   endtask : t_refuse
   task automatic t_mult_shared();
      multValue <= 4'h3;
      multLoad <= 1'b1;
      @(negedge clk);
      multLoad <= 1'b0;
      @(negedge clk);
      check("multiplier", 4'h3, coreClockMult);
      dataPortSelectN <= 1'b0;
      repeat (5) @(negedge clk);
      check("data select", 1, dataPortActive);
      check("data byte sync", 1, syncCount);
      dataPortSelectN <= 1'b1;
      sharedSelectMode <= 1'b1;
      repeat (10) @(negedge clk);
      check("shared data select", 1, dataPortActive);
      t_read(8'h5a, 16'hbeef);
      repeat (10) @(negedge clk);
      check("byte sync count", 2, syncCount);
      $display("shared test done");
   endtask : t_mult_shared
   initial begin
      #500us;
      err_count++;
      print_verdict();
   end
   initial begin
      repeat (16) @(negedge clk);
      resetn <= 1'b1;
      check("reset multiplier", MULT_1X, coreClockMult);
      wait_flag();
      regUpdate <= '{1'b1, 8'h5a, 16'hbeef};
      @(negedge clk);
      regUpdate <= '{1'b1, 8'h5b, 16'h1234};
      @(negedge clk);
      regUpdate <= '0;
      t_read(8'h5a, 16'hbeef);
      t_read(8'h5b, 16'h1234);
      t_write();
      t_refuse();
      t_mult_shared();
      print_verdict();
   end
endmodule : scmi_command_port_test
